// [hw/status_event_pkg.sv]
package status_event_pkg;

	// ----------------------------------------------------------------
	// Register geometry
	// ----------------------------------------------------------------
	localparam int unsigned PART_W        = 16;
	localparam int unsigned DATA_W        = 15;
	localparam int unsigned NUM_SUB       = 30;
	localparam int unsigned SUB_PER_GROUP = 15;
	localparam int unsigned NUM_REGS      = 33;

	// ----------------------------------------------------------------
	// Register selector codes on the command port
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_TOP      = 6'h00;
	localparam logic [5:0] REG_GRP1     = 6'h01;
	localparam logic [5:0] REG_GRP2     = 6'h02;
	localparam logic [5:0] REG_SUB_BASE = 6'h03;
	localparam logic [5:0] REG_LAST     = 6'h20;

	// ----------------------------------------------------------------
	// Part selector codes
	// ----------------------------------------------------------------
	localparam logic [2:0] PART_LIVE  = 3'h0;
	localparam logic [2:0] PART_RISE  = 3'h1;
	localparam logic [2:0] PART_FALL  = 3'h2;
	localparam logic [2:0] PART_EVENT = 3'h3;
	localparam logic [2:0] PART_MASK  = 3'h4;

	// ----------------------------------------------------------------
	// Reset values of the writable parts
	// ----------------------------------------------------------------
	localparam logic [14:0] RISE_RST = 15'h7FFF;
	localparam logic [14:0] FALL_RST = 15'h0000;
	localparam logic [14:0] MASK_RST = 15'h0000;

	// ----------------------------------------------------------------
	// Where the two group sums land in the top operation register
	// ----------------------------------------------------------------
	localparam int unsigned TOP_GRP1_BIT = 8;
	localparam int unsigned TOP_GRP2_BIT = 9;

endpackage

// [hw/status_reg_cell.sv]
`timescale 1ns/1ps

module status_reg_cell (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [14:0] i_cond,
	input  wire logic [14:0] i_set,
	input  wire logic        i_wr_rise,
	input  wire logic        i_wr_fall,
	input  wire logic        i_wr_mask,
	input  wire logic [14:0] i_wdata,
	input  wire logic        i_rd_event,
	output logic      [14:0] o_rise,
	output logic      [14:0] o_fall,
	output logic      [14:0] o_event,
	output logic      [14:0] o_mask,
	output logic             o_sum
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [14:0] prev_q;
	logic [14:0] rise_q;
	logic [14:0] fall_q;
	logic [14:0] event_q;
	logic [14:0] event_d;
	logic [14:0] mask_q;
	wire  [14:0] rose_w;
	wire  [14:0] fell_w;
	wire  [14:0] pass_w;

	// ----------------------------------------------------------------
	// Transition filters
	// ----------------------------------------------------------------
	assign rose_w = i_cond & ~prev_q & rise_q;
	assign fell_w = ~i_cond & prev_q & fall_q;
	assign pass_w = rose_w | fell_w | i_set;

	// Set beats the clearing read so an event in that cycle survives
	assign event_d = (i_rd_event ? 15'h0000 : event_q) | pass_w;

	// Bitwise ops keep every bit position independent
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_q  <= i_cond;
			rise_q  <= status_event_pkg::RISE_RST;
			fall_q  <= status_event_pkg::FALL_RST;
			event_q <= 15'h0000;
			mask_q  <= status_event_pkg::MASK_RST;
		end else begin
			prev_q  <= i_cond;
			event_q <= event_d;
			if (i_wr_rise) begin
				rise_q <= i_wdata;
			end
			if (i_wr_fall) begin
				fall_q <= i_wdata;
			end
			if (i_wr_mask) begin
				mask_q <= i_wdata;
			end
		end
	end

	assign o_rise  = rise_q;
	assign o_fall  = fall_q;
	assign o_event = event_q;
	assign o_mask  = mask_q;
	assign o_sum   = |(event_q & mask_q);

endmodule

// [hw/status_event_summary_register.sv]
`timescale 1ns/1ps


module status_event_summary_register (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [449:0] i_sub_cond,
	input  wire logic [449:0] i_sub_set,
	input  wire logic [14:0]  i_top_cond,
	input  wire logic [14:0]  i_top_set,
	input  wire logic         i_cmd_valid,
	input  wire logic         i_cmd_write,
	input  wire logic [5:0]   i_cmd_reg,
	input  wire logic [2:0]   i_cmd_part,
	input  wire logic [15:0]  i_cmd_wdata,
	output logic              o_rsp_valid,
	output logic      [15:0]  o_rsp_data,
	output logic              o_rsp_error,
	output logic              o_oper_summary
);

	// ----------------------------------------------------------------
	// Per-register arrays
	// ----------------------------------------------------------------
	localparam int unsigned NR = status_event_pkg::NUM_REGS;
	localparam int unsigned NS = status_event_pkg::SUB_PER_GROUP;

	wire  [14:0] cond_a  [0:NR-1];
	wire  [14:0] set_a   [0:NR-1];
	wire  [14:0] rise_a  [0:NR-1];
	wire  [14:0] fall_a  [0:NR-1];
	wire  [14:0] event_a [0:NR-1];
	wire  [14:0] mask_a  [0:NR-1];
	wire  [NR-1:0] sum_w;
	wire  [14:0] grp1_sums;
	wire  [14:0] grp2_sums;
	wire  [14:0] top_cond_w;
	wire  [14:0] top_keep_w;
	wire  [14:0] top_sums_w;
	wire  [NR-1:0] hit_v;
	wire  [NR-1:0] wr_rise_v;
	wire  [NR-1:0] wr_fall_v;
	wire  [NR-1:0] wr_mask_v;
	wire  [NR-1:0] rd_event_v;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire        reg_ok_w;
	wire        part_ok_w;
	wire        ro_part_w;
	wire        bad_w;
	wire        do_wr_w;
	wire        do_rd_w;
	wire [5:0]  sel_w;
	wire [14:0] wdata_w;
	wire        reg_bad_w;
	wire        part_bad_w;
	wire        ro_write_w;
	wire        is_live_w;
	wire        is_rise_w;
	wire        is_fall_w;
	wire        is_event_w;
	wire        is_mask_w;
	wire        rsp_valid_d;
	wire        rsp_error_d;
	wire [14:0] live_rd_w;
	wire [14:0] rise_rd_w;
	wire [14:0] fall_rd_w;
	wire [14:0] event_rd_w;
	wire [14:0] mask_rd_w;

	logic        rsp_valid_q;
	logic [15:0] rsp_data_q;
	logic [15:0] rsp_data_d;
	logic        rsp_error_q;

	// ----------------------------------------------------------------
	// Selector range checks
	// ----------------------------------------------------------------
	// One register and one part per command
	assign reg_ok_w   = (i_cmd_reg <= status_event_pkg::REG_LAST);
	assign part_ok_w  = (i_cmd_part <= status_event_pkg::PART_MASK);
	assign reg_bad_w  = !reg_ok_w;
	assign part_bad_w = !part_ok_w;

	// ----------------------------------------------------------------
	// Part decode
	// ----------------------------------------------------------------
	assign is_live_w  = (i_cmd_part == status_event_pkg::PART_LIVE);
	assign is_rise_w  = (i_cmd_part == status_event_pkg::PART_RISE);
	assign is_fall_w  = (i_cmd_part == status_event_pkg::PART_FALL);
	assign is_event_w = (i_cmd_part == status_event_pkg::PART_EVENT);
	assign is_mask_w  = (i_cmd_part == status_event_pkg::PART_MASK);
	assign ro_part_w  = is_live_w || is_event_w;

	// ----------------------------------------------------------------
	// Refusal and strobes
	// ----------------------------------------------------------------
	// A write to a read-only part is refused and changes nothing
	assign ro_write_w = i_cmd_write && ro_part_w;
	assign bad_w      = reg_bad_w || part_bad_w || ro_write_w;
	assign do_wr_w    = i_cmd_valid && i_cmd_write && !bad_w;
	assign do_rd_w    = i_cmd_valid && !i_cmd_write && !bad_w;
	assign sel_w      = reg_ok_w ? i_cmd_reg : 6'h00;
	// Bit 15 is never stored, so a written one there is dropped
	assign wdata_w    = i_cmd_wdata[14:0];

	// ----------------------------------------------------------------
	// Hierarchy wiring
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_grp
			// Sub-register nr n sits on group bit n-1; bit 15 must stay zero
			assign grp1_sums[g] = sum_w[3 + g];
			assign grp2_sums[g] = sum_w[3 + NS + g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Top operation register input
	// ----------------------------------------------------------------
	// Questionable branch is absent; only these paths exist
	// The group sum positions ignore i_top_cond; i_top_set still sets their events
	assign top_keep_w = ~((15'h0001 << status_event_pkg::TOP_GRP1_BIT) |
	                      (15'h0001 << status_event_pkg::TOP_GRP2_BIT));
	assign top_sums_w = ({14'h0000, sum_w[1]} << status_event_pkg::TOP_GRP1_BIT) |
	                    ({14'h0000, sum_w[2]} << status_event_pkg::TOP_GRP2_BIT);
	assign top_cond_w = (i_top_cond & top_keep_w) | top_sums_w;

	// ----------------------------------------------------------------
	// Live and set inputs per register
	// ----------------------------------------------------------------

	assign cond_a[0] = top_cond_w;
	assign cond_a[1] = grp1_sums;
	assign cond_a[2] = grp2_sums;
	assign set_a[0]  = i_top_set;
	assign set_a[1]  = 15'h0000;
	assign set_a[2]  = 15'h0000;

	generate
		for (g = 0; g < status_event_pkg::NUM_SUB; g++) begin : g_sub
			// Secondary address g lands on register 3+g
			assign cond_a[3 + g] = i_sub_cond[g*15 +: 15];
			assign set_a[3 + g]  = i_sub_set[g*15 +: 15];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register cells
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < NR; g++) begin : g_cell
			assign hit_v[g]      = (sel_w == 6'(g));
			assign wr_rise_v[g]  = do_wr_w && hit_v[g] && is_rise_w;
			assign wr_fall_v[g]  = do_wr_w && hit_v[g] && is_fall_w;
			assign wr_mask_v[g]  = do_wr_w && hit_v[g] && is_mask_w;
			// Only the addressed register loses its events on a read
			assign rd_event_v[g] = do_rd_w && hit_v[g] && is_event_w;

			status_reg_cell u_cell (
				.i_clk      (i_clk),
				.i_rst      (i_rst),
				.i_cond     (cond_a[g]),
				.i_set      (set_a[g]),
				.i_wr_rise  (wr_rise_v[g]),
				.i_wr_fall  (wr_fall_v[g]),
				.i_wr_mask  (wr_mask_v[g]),
				.i_wdata    (wdata_w),
				.i_rd_event (rd_event_v[g]),
				.o_rise     (rise_a[g]),
				.o_fall     (fall_a[g]),
				.o_event    (event_a[g]),
				.o_mask     (mask_a[g]),
				.o_sum      (sum_w[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Each part has its own read mux on the shared sel_w, and no selector feeds back into storage
	assign live_rd_w  = cond_a[sel_w];
	assign rise_rd_w  = rise_a[sel_w];
	assign fall_rd_w  = fall_a[sel_w];
	assign event_rd_w = event_a[sel_w];
	assign mask_rd_w  = mask_a[sel_w];

	// Reads of live, filters and mask have no side effect on storage
	// Data are zero outside a read so a stale word is never taken for one
	always_comb begin
		rsp_data_d = 16'h0000;
		if (do_rd_w) begin
			case (i_cmd_part)
				status_event_pkg::PART_LIVE: begin
					rsp_data_d = {1'b0, live_rd_w};
				end
				status_event_pkg::PART_RISE: begin
					rsp_data_d = {1'b0, rise_rd_w};
				end
				status_event_pkg::PART_FALL: begin
					rsp_data_d = {1'b0, fall_rd_w};
				end
				status_event_pkg::PART_EVENT: begin
					rsp_data_d = {1'b0, event_rd_w};
				end
				status_event_pkg::PART_MASK: begin
					rsp_data_d = {1'b0, mask_rd_w};
				end
				default: begin
					rsp_data_d = 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Response registers
	// ----------------------------------------------------------------
	// Every command gets exactly one response pulse, refused or not
	assign rsp_valid_d = i_cmd_valid;
	assign rsp_error_d = i_cmd_valid && bad_w;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= rsp_valid_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rsp_data_q <= 16'h0000;
		end else begin
			rsp_data_q <= rsp_data_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rsp_error_q <= 1'b0;
		end else begin
			rsp_error_q <= rsp_error_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_data  = rsp_data_q;
	assign o_rsp_error = rsp_error_q;

	// Status byte logic downstream gates this with its own enable
	assign o_oper_summary = sum_w[0];

endmodule

// [dv/status_event_props.sv]
`timescale 1ns/1ps

module status_event_props (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_cmd_valid,
	input  wire logic        i_cmd_write,
	input  wire logic [5:0]  i_cmd_reg,
	input  wire logic [2:0]  i_cmd_part,
	input  wire logic        o_rsp_valid,
	input  wire logic [15:0] o_rsp_data,
	input  wire logic        o_rsp_error,
	input  wire logic        o_oper_summary
);
	// ----
	// Response and summary output checks
	// ----
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire wr = i_cmd_valid && i_cmd_write;
	wire bad = i_cmd_reg > 6'h20 || i_cmd_part > 3'h4;

	rsp_timing_a: assert property (!$past(i_rst) |-> o_rsp_valid == $past(i_cmd_valid))
		else $error("response pulse not one cycle after command");
	msb_zero_a: assert property (!o_rsp_data[15])
		else $error("read data bit 15 set");
	live_ro_a: assert property (wr && i_cmd_part == 3'h0 |=> o_rsp_error && o_rsp_data == 16'h0000)
		else $error("write to live part accepted");
	event_ro_a: assert property (wr && i_cmd_part == 3'h3 |=> o_rsp_error)
		else $error("write to event part accepted");
	bad_sel_a: assert property (i_cmd_valid && bad |=> o_rsp_valid && o_rsp_error)
		else $error("bad selector not refused");
	good_rd_a: assert property (i_cmd_valid && !i_cmd_write && !bad |=> !o_rsp_error)
		else $error("valid read refused");
	wr_data_a: assert property (wr |=> o_rsp_data == 16'h0000)
		else $error("write response carries data");
	mask_rst_a: assert property ($fell(i_rst) |-> !o_oper_summary)
		else $error("summary set with cleared masks");
endmodule

bind status_event_summary_register status_event_props i_status_event_props (
	.i_clk, .i_rst, .i_cmd_valid, .i_cmd_write, .i_cmd_reg, .i_cmd_part,
	.o_rsp_valid, .o_rsp_data, .o_rsp_error, .o_oper_summary);

// [dv/remote_ctrl.sv]
`timescale 1ns/1ps

module remote_ctrl (
	input  wire logic        i_clk,
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_data,
	input  wire logic        i_rsp_error,
	output logic             o_valid,
	output logic             o_write,
	output logic      [5:0]  o_reg,
	output logic      [2:0]  o_part,
	output logic      [15:0] o_wdata
);
	// ----
	// One register, one part per command
	// ----
	logic [15:0] rd;
	logic        er;
	logic        vl;
	initial begin
		o_valid = 1'b0;
		o_write = 1'b0;
		o_reg = 6'h00;
		o_part = 3'h0;
		o_wdata = 16'h0000;
	end
	task automatic acc(input logic w, input logic [5:0] r, input logic [2:0] p,
		input logic [15:0] d);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_write <= w;
		o_reg <= r;
		o_part <= p;
		o_wdata <= d;
		@(posedge i_clk);
		o_valid <= 1'b0;
		// Stale data is inverted so a design cannot lean on it
		o_wdata <= ~d;
		#1;
		rd = i_rsp_data;
		er = i_rsp_error;
		vl = i_rsp_valid;
	endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps

module testbench;
	// ----
	// Harness
	// ----
	logic         i_clk = 1'b0;
	logic         i_rst = 1'b1;
	logic [449:0] sub_cond = '0;
	logic [449:0] sub_set = '0;
	logic [14:0]  top_cond = '0;
	logic [14:0]  top_set = '0;
	logic         cv, cw, rv, re, os;
	logic [5:0]   cr;
	logic [2:0]   cp;
	logic [15:0]  cd, rdat;
	int           error_cnt = 0;
	int           checked = 0;
	always #5 i_clk = ~i_clk;
	status_event_summary_register i_status_event_summary_register (.i_clk, .i_rst,
		.i_sub_cond(sub_cond), .i_sub_set(sub_set), .i_top_cond(top_cond),
		.i_top_set(top_set), .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_reg(cr),
		.i_cmd_part(cp), .i_cmd_wdata(cd), .o_rsp_valid(rv), .o_rsp_data(rdat),
		.o_rsp_error(re), .o_oper_summary(os));
	remote_ctrl i_remote_ctrl (.i_clk, .i_rsp_valid(rv), .i_rsp_data(rdat),
		.i_rsp_error(re), .o_valid(cv), .o_write(cw), .o_reg(cr), .o_part(cp),
		.o_wdata(cd));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [5:0] r, input logic [2:0] p, input logic [15:0] e);
		i_remote_ctrl.acc(1'b0, r, p, 16'h0000);
		chk(16'({i_remote_ctrl.vl, i_remote_ctrl.er}), 16'h0002);
		chk(i_remote_ctrl.rd, e);
	endtask
	task automatic wrerr(input logic w, input logic [5:0] r, input logic [2:0] p);
		i_remote_ctrl.acc(w, r, p, 16'h7FFF);
		chk(16'({i_remote_ctrl.vl, i_remote_ctrl.er}), 16'h0003);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic s_regs;
		logic [2:0]  pt [3] = '{3'h1, 3'h2, 3'h4};
		logic [15:0] rv0 [3] = '{16'h7FFF, 16'h0000, 16'h0000};
		for (int k = 0; k < 3; k++) begin
			rdchk(6'h05, pt[k], rv0[k]);
			i_remote_ctrl.acc(1'b1, 6'h05, pt[k], 16'hFFFF);
			rdchk(6'h05, pt[k], 16'h7FFF);
			rdchk(6'h05, pt[k], 16'h7FFF);
		end
	endtask
	task automatic s_refuse;
		wrerr(1'b1, 6'h03, 3'h0);
		wrerr(1'b1, 6'h03, 3'h3);
		wrerr(1'b0, 6'h21, 3'h0);
		wrerr(1'b0, 6'h03, 3'h5);
		rdchk(6'h03, 3'h0, 16'h0000);
	endtask
	task automatic s_edge;
		i_remote_ctrl.acc(1'b1, 6'h03, 3'h1, 16'h0001);
		i_remote_ctrl.acc(1'b1, 6'h03, 3'h2, 16'h0002);
		@(posedge i_clk);
		sub_cond[1:0] <= 2'b11;
		rdchk(6'h03, 3'h0, 16'h0003);
		rdchk(6'h03, 3'h3, 16'h0001);
		@(posedge i_clk);
		sub_cond[1:0] <= 2'b00;
		repeat (2) @(posedge i_clk);
		rdchk(6'h03, 3'h3, 16'h0002);
		rdchk(6'h03, 3'h3, 16'h0000);
	endtask
	task automatic s_cascade;
		i_remote_ctrl.acc(1'b1, 6'h20, 3'h4, 16'h4000);
		i_remote_ctrl.acc(1'b1, 6'h02, 3'h4, 16'h4000);
		@(posedge i_clk);
		sub_set[449] <= 1'b1;
		@(posedge i_clk);
		sub_set[449] <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		chk(16'(os), 16'h0000);
		rdchk(6'h02, 3'h0, 16'h4000);
		i_remote_ctrl.acc(1'b1, 6'h00, 3'h4, 16'h0200);
		chk(16'(os), 16'h0001);
		rdchk(6'h00, 3'h3, 16'h0200);
		chk(16'(os), 16'h0000);
	endtask
	// A set landing on a clearing read must survive it
	task automatic s_lost;
		fork
			rdchk(6'h04, 3'h3, 16'h0000);
			begin
				@(posedge i_clk);
				sub_set[15] <= 1'b1;
				@(posedge i_clk);
				sub_set[15] <= 1'b0;
			end
		join
		rdchk(6'h04, 3'h3, 16'h0001);
	endtask
	// Group sum positions of the top register ignore the hardware condition input
	task automatic s_top;
		@(posedge i_clk);
		top_cond <= 15'h0301;
		top_set <= 15'h0008;
		@(posedge i_clk);
		top_set <= 15'h0000;
		rdchk(6'h00, 3'h0, 16'h0201);
		chk(16'(os), 16'h0000);
		rdchk(6'h00, 3'h3, 16'h0009);
	endtask
	// Mid-run reset restores the mask and fall parts and raises no false edge
	task automatic s_reset;
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rdchk(6'h05, 3'h4, 16'h0000);
		rdchk(6'h03, 3'h2, 16'h0000);
		rdchk(6'h00, 3'h3, 16'h0000);
		chk(16'(os), 16'h0000);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		s_regs();
		s_refuse();
		s_edge();
		s_cascade();
		s_lost();
		s_top();
		s_reset();
		tally_and_finish();
	end
	// Tests take about a hundred cycles; this is far beyond
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
